// ### core/tms_ctrl.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tms_ctrl #(
  parameter int unsigned INTEG_CYCLES = tms_pkg::INTEG_CYCLES_DEF,
  parameter int unsigned BASE_CYCLES = tms_pkg::SAMPLE_BASE_CYCLES,
  parameter logic [6:0] DEV_ADDR = tms_pkg::I2C_DEV_ADDR_DEF
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_scl_clk,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic i_chip_enable_low,
  input wire logic i_sample_start,
  output logic o_irq_out,
  output logic o_irq_oe_n,
  output logic o_bias_enable,
  output logic o_emitter_pulse_en,
  output logic [tms_pkg::EMIT_RANGE_W-1:0] o_emitter_range,
  output logic [7:0] o_emitter_fine,
  output logic o_threshold_en,
  output logic [7:0] o_threshold_code,
  output logic o_meas_done
);
  import tms_pkg::*;
  localparam int IW = $clog2(INTEG_CYCLES);
  localparam logic [IW-1:0] INTEG_LAST = IW'(INTEG_CYCLES - 1);
  if (INTEG_CYCLES < 2 || INTEG_CYCLES > 4096) begin : g_bad_integ
    $error("INTEG_CYCLES must lie in 2..4096");
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic link_wr_tgl;
  logic link_ptr_tgl;
  logic link_rc_tgl;
  logic [7:0] link_wr_addr;
  logic [7:0] link_wr_data;
  logic [7:0] link_ptr;
  logic [7:0] rd_hold;
  logic [7:0] rd_value;
  logic [2:0] tgl_meta;
  logic [2:0] tgl_sync;
  logic [2:0] tgl_prev;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic ss_prev;
  logic wr_fire;
  logic ptr_fire;
  logic rc_fire;

  // Serial link stays clocked by the host whatever the enable state.
  // link always alive
  tms_i2c_link #(
    .DEV_ADDR(DEV_ADDR)
  ) u_link (
    .i_scl_clk(i_scl_clk),
    .i_sda_in(i_sda_in),
    .i_reset(i_reset),
    .i_rd_data(rd_hold),
    .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n),
    .o_wr_tgl(link_wr_tgl),
    .o_wr_addr(link_wr_addr),
    .o_wr_data(link_wr_data),
    .o_ptr_tgl(link_ptr_tgl),
    .o_ptr(link_ptr),
    .o_rc_tgl(link_rc_tgl)
  );

  // Toggles from the link and the two pins pass two flops before use.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tgl_meta <= 3'h0;
      tgl_sync <= 3'h0;
      tgl_prev <= 3'h0;
      pin_meta <= 2'h1;
      pin_sync <= 2'h1;
      ss_prev <= 1'b0;
    end else if (i_clk_en) begin
      tgl_meta <= {link_rc_tgl, link_ptr_tgl, link_wr_tgl};
      tgl_sync <= tgl_meta;
      tgl_prev <= tgl_sync;
      pin_meta <= {i_sample_start, i_chip_enable_low};
      pin_sync <= pin_meta;
      ss_prev <= pin_sync[1];
    end
  end
  assign wr_fire = i_clk_en && (tgl_sync[0] ^ tgl_prev[0]);
  assign ptr_fire = i_clk_en && (tgl_sync[1] ^ tgl_prev[1]);
  assign rc_fire = i_clk_en && (tgl_sync[2] ^ tgl_prev[2]);

  ////////////////////////////////////////////////////////////////////////////////
  logic cmd_start;
  logic cmd_reset;
  logic cmd_clear;
  logic sw_disable;
  logic brownout;
  logic mode_single;
  logic irq_en;
  logic int_done;
  logic next_int_done;
  logic [7:0] sample_period;
  logic [7:0] period_range;
  logic [7:0] meas_count;
  logic dev_en;
  logic trig;
  logic done;

  assign cmd_start = wr_fire && link_wr_addr == REG_COMMAND && link_wr_data == CMD_SOFT_START;
  assign cmd_reset = wr_fire && link_wr_addr == REG_COMMAND && link_wr_data == CMD_SOFT_RESET;
  assign cmd_clear = wr_fire && link_wr_addr == REG_COMMAND && link_wr_data == CMD_SOFT_CLEAR;
  assign dev_en = !pin_sync[0] && !sw_disable;
  assign trig = dev_en && ((pin_sync[1] && !ss_prev) || cmd_start);

  // Only writes and the soft reset touch these; chip enable never does.
  // defaults on reset
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sw_disable <= RST_SW_DISABLE;
      sample_period <= RST_SAMPLE_PERIOD;
      period_range <= RST_PERIOD_RANGE;
      mode_single <= RST_MODE_SINGLE;
      irq_en <= RST_IRQ_EN;
      o_emitter_range <= RST_EMIT_RANGE;
      o_emitter_fine <= RST_EMIT_FINE;
      o_threshold_code <= RST_THRESHOLD;
    end else if (i_clk_en) begin
      if (cmd_reset) begin
        sw_disable <= RST_SW_DISABLE;
        sample_period <= RST_SAMPLE_PERIOD;
        period_range <= RST_PERIOD_RANGE;
        mode_single <= RST_MODE_SINGLE;
        irq_en <= RST_IRQ_EN;
        o_emitter_range <= RST_EMIT_RANGE;
        o_emitter_fine <= RST_EMIT_FINE;
        o_threshold_code <= RST_THRESHOLD;
      end else if (wr_fire) begin
        case (link_wr_addr)
          REG_SW_DISABLE: sw_disable <= link_wr_data[DISABLE_BIT];
          REG_SAMPLE_PERIOD: sample_period <= link_wr_data;
          REG_PERIOD_RANGE: period_range <= link_wr_data;
          REG_MODE: mode_single <= link_wr_data[MODE_SINGLE_BIT];
          REG_INT_CTRL: irq_en <= link_wr_data[IRQ_EN_BIT];
          REG_EMIT_RANGE: o_emitter_range <= link_wr_data[EMIT_RANGE_W-1:0];
          REG_EMIT_FINE: o_emitter_fine <= link_wr_data;
          REG_THRESHOLD: o_threshold_code <= link_wr_data;
          default: begin
          end
        endcase
      end
    end
  end

  // Brownout survives the soft reset; power-on sets it, software clears it.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      brownout <= 1'b1;
    end else if (i_clk_en && wr_fire && link_wr_addr == REG_POWER_STATUS) begin
      brownout <= link_wr_data[BROWNOUT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  tms_seq_state_t state;
  tms_seq_state_t next_state;
  logic [IW-1:0] integ_cnt;
  logic period_expired;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (trig) next_state = ST_INTEG;
      end
      ST_INTEG: begin
        if (integ_cnt == INTEG_LAST) next_state = mode_single ? ST_IDLE : ST_WAIT;
      end
      ST_WAIT: begin
        if (mode_single) next_state = ST_IDLE;
        else if (period_expired) next_state = ST_INTEG;
      end
      default: next_state = ST_IDLE;
    endcase
    if (!dev_en || cmd_clear || cmd_reset) next_state = ST_IDLE;
  end
  assign done = state == ST_INTEG && integ_cnt == INTEG_LAST && next_state != ST_IDLE ||
                state == ST_INTEG && integ_cnt == INTEG_LAST && mode_single && dev_en && !cmd_clear && !cmd_reset;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) state <= ST_IDLE;
    else if (i_clk_en) state <= next_state;
  end

  // The integration count is the accumulator that a soft clear empties.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) integ_cnt <= '0;
    else if (i_clk_en) integ_cnt <= (state == ST_INTEG && next_state == ST_INTEG) ? integ_cnt + IW'(1) : '0;
  end

  tms_period_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_start(state != ST_INTEG && next_state == ST_INTEG),
    .i_stop(next_state == ST_IDLE),
    .i_period(sample_period),
    .i_range(period_range[3:0]),
    .o_expired(period_expired)
  );

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_threshold_en <= 1'b0;
      o_emitter_pulse_en <= 1'b0;
      o_bias_enable <= 1'b0;
      o_meas_done <= 1'b0;
    end else if (i_clk_en) begin
      o_threshold_en <= next_state == ST_INTEG;
      o_emitter_pulse_en <= next_state == ST_INTEG;
      o_bias_enable <= dev_en;
      o_meas_done <= done;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) meas_count <= 8'h00;
    else if (i_clk_en && (cmd_clear || cmd_reset)) meas_count <= 8'h00;
    else if (i_clk_en && done) meas_count <= meas_count + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A completion in the same cycle as the clearing read wins over the clear.
  // clear on read
  assign next_int_done = done || (int_done && !rc_fire && !cmd_reset);
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) int_done <= 1'b0;
    else if (i_clk_en) int_done <= next_int_done;
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_irq_out <= 1'b0;
      o_irq_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      o_irq_out <= 1'b0;
      o_irq_oe_n <= !(next_int_done && irq_en);
    end
  end

  always_comb begin
    rd_value = 8'h00;
    case (link_ptr)
      REG_SW_DISABLE: rd_value[DISABLE_BIT] = sw_disable;
      REG_POWER_STATUS: rd_value[BROWNOUT_BIT] = brownout;
      REG_SAMPLE_PERIOD: rd_value = sample_period;
      REG_PERIOD_RANGE: rd_value = period_range;
      REG_MODE: rd_value[MODE_SINGLE_BIT] = mode_single;
      REG_INT_STATUS: rd_value[DONE_BIT] = int_done;
      REG_INT_CTRL: rd_value[IRQ_EN_BIT] = irq_en;
      REG_MEAS_COUNT: rd_value = meas_count;
      REG_EMIT_RANGE: rd_value[EMIT_RANGE_W-1:0] = o_emitter_range;
      REG_EMIT_FINE: rd_value = o_emitter_fine;
      REG_THRESHOLD: rd_value = o_threshold_code;
      default: rd_value = 8'h00;
    endcase
  end

  // The word is fetched when the pointer moves and then held for the link.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) rd_hold <= 8'h00;
    else if (ptr_fire) rd_hold <= rd_value;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  AST_POR_IDLE: assert property ($fell(i_reset) |-> state == ST_IDLE && !sw_disable && !mode_single)
    else $error("sequencer or registers not at default after reset");
  AST_DISABLED_IDLE: assert property (i_clk_en && !dev_en |=> state == ST_IDLE && !o_emitter_pulse_en)
    else $error("sequencer ran while disabled");
  AST_REGS_KEEP: assert property (i_clk_en && !wr_fire |=> $stable(sample_period) && $stable(o_emitter_fine))
    else $error("register changed without a write");
  AST_BUSY_IGNORE: assert property (i_clk_en && state == ST_INTEG && trig && !cmd_clear && !cmd_reset &&
                                    integ_cnt != INTEG_LAST |=> state == ST_INTEG && integ_cnt == $past(integ_cnt) + IW'(1))
    else $error("trigger disturbed a running measurement");
  AST_SOFT_START: assert property (i_clk_en && cmd_start && state == ST_IDLE && dev_en |=> state == ST_INTEG)
    else $error("soft start did not begin a measurement");
  AST_SOFT_CLEAR: assert property (i_clk_en && cmd_clear |=> state == ST_IDLE && integ_cnt == '0)
    else $error("soft clear did not halt the sequencer");
  // A fresh trigger right after completion may legally start the next shot.
  AST_SINGLE_STOP: assert property (i_clk_en && done && mode_single |=>
                                    state == ST_IDLE ##1 (state == ST_IDLE || $past(trig)))
    else $error("single shot did not stop");
  AST_IRQ_HOLD: assert property (!o_irq_oe_n && !rc_fire && !cmd_reset && irq_en |=> !o_irq_oe_n)
    else $error("interrupt released before status read");
  AST_IRQ_NO_HIGH: assert property (o_irq_out == 1'b0)
    else $error("interrupt pin drove high");
  AST_THRESH_GATE: assert property (o_threshold_en == (state == ST_INTEG))
    else $error("threshold current outside integration");
  AST_DONE_IRQ: assert property (i_clk_en && done && irq_en |=> !o_irq_oe_n && int_done)
    else $error("completion did not raise interrupt");

  COV_SINGLE: cover property (mode_single && done ##1 state == ST_IDLE);
  COV_CONT: cover property (state == ST_WAIT ##1 state == ST_INTEG);
  COV_READ_CLEAR: cover property (!o_irq_oe_n ##1 rc_fire ##1 o_irq_oe_n);
  COV_SOFT_RESET: cover property (cmd_reset);
endmodule // tms_ctrl

// ### core/tms_pkg.sv
package tms_pkg;
  localparam logic [7:0] REG_SW_DISABLE = 8'h01;
  localparam logic [7:0] REG_POWER_STATUS = 8'h02;
  localparam logic [7:0] REG_SAMPLE_PERIOD = 8'h11;
  localparam logic [7:0] REG_PERIOD_RANGE = 8'h12;
  localparam logic [7:0] REG_MODE = 8'h13;
  localparam logic [7:0] REG_INT_STATUS = 8'h60;
  localparam logic [7:0] REG_INT_CTRL = 8'h61;
  localparam logic [7:0] REG_MEAS_COUNT = 8'h64;
  localparam logic [7:0] REG_EMIT_RANGE = 8'h90;
  localparam logic [7:0] REG_EMIT_FINE = 8'h91;
  localparam logic [7:0] REG_THRESHOLD = 8'h93;
  localparam logic [7:0] REG_COMMAND = 8'hB0;
  localparam logic [7:0] CMD_SOFT_START = 8'h49;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hD7;
  localparam logic [7:0] CMD_SOFT_CLEAR = 8'hD1;
  localparam int DISABLE_BIT = 0;
  localparam int BROWNOUT_BIT = 0;
  localparam int MODE_SINGLE_BIT = 0;
  localparam int DONE_BIT = 0;
  localparam int IRQ_EN_BIT = 0;
  localparam int EMIT_RANGE_W = 4;
  localparam logic RST_SW_DISABLE = 1'b0;
  localparam logic RST_MODE_SINGLE = 1'b0;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic [7:0] RST_SAMPLE_PERIOD = 8'h00;
  localparam logic [7:0] RST_PERIOD_RANGE = 8'h00;
  localparam logic [EMIT_RANGE_W-1:0] RST_EMIT_RANGE = 4'h0;
  localparam logic [7:0] RST_EMIT_FINE = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  // Device address on the serial link; the value is arbitrary.
  localparam logic [6:0] I2C_DEV_ADDR_DEF = 7'h50;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SAMPLE_BASE_NS = 450000;
  localparam int INTEG_TIME_NS = 4000;
  localparam int SAMPLE_BASE_CYCLES = (SAMPLE_BASE_NS * 1000) / CLK_PERIOD_PS;
  localparam int INTEG_CYCLES_DEF = (INTEG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TICK_W = 24;
  typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_WAIT} tms_seq_state_t;
  typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_PTR, LK_WDATA, LK_RDATA} tms_link_phase_t;
endpackage

// ### core/tms_period_timer.sv
`timescale 1ns/1ps
module tms_period_timer #(
  parameter int unsigned BASE_CYCLES = tms_pkg::SAMPLE_BASE_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [7:0] i_period,
  input wire logic [3:0] i_range,
  output logic o_expired
);
  import tms_pkg::*;
  localparam int BW = $clog2(BASE_CYCLES);
  if (BASE_CYCLES < 2) begin : g_bad_base
    $error("BASE_CYCLES must be at least 2");
  end
  logic [BW-1:0] base_cnt;
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] target;
  logic running;
  // Interval is 1 + period * 2^range base ticks, counted from measurement start.
  assign target = TICK_W'(1) + (TICK_W'(i_period) << i_range);
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      base_cnt <= '0;
      tick_cnt <= '0;
      running <= 1'b0;
      o_expired <= 1'b0;
    end else if (i_clk_en) begin
      if (i_start) begin
        // The start edge is itself the first cycle, so the restart lands on the period.
        base_cnt <= BW'(1);
        tick_cnt <= '0;
        running <= 1'b1;
        o_expired <= 1'b0;
      end else if (i_stop) begin
        running <= 1'b0;
        o_expired <= 1'b0;
      end else if (running && !o_expired) begin
        if (base_cnt == BW'(BASE_CYCLES - 1)) begin
          base_cnt <= '0;
          tick_cnt <= tick_cnt + TICK_W'(1);
          o_expired <= (tick_cnt + TICK_W'(1)) >= target;
        end else begin
          base_cnt <= base_cnt + BW'(1);
        end
      end
    end
  end
endmodule // tms_period_timer

// ### core/tms_i2c_link.sv
`timescale 1ns/1ps
module tms_i2c_link #(
  parameter logic [6:0] DEV_ADDR = tms_pkg::I2C_DEV_ADDR_DEF
) (
  input wire logic i_scl_clk,
  input wire logic i_sda_in,
  input wire logic i_reset,
  input wire logic [7:0] i_rd_data,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_wr_tgl,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_ptr_tgl,
  output logic [7:0] o_ptr,
  output logic o_rc_tgl
);
  import tms_pkg::*;
  logic start_seen;
  logic start_ack;
  logic start_clr;
  logic ack_pend;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx_byte;
  logic [7:0] byte_now;
  tms_link_phase_t phase;
  assign start_clr = i_reset | start_ack;
  assign byte_now = {shreg[6:0], i_sda_in};
  // A start is SDA falling while SCL is high; the first SCL rise retires it.
  always_ff @(negedge i_sda_in or posedge start_clr) begin
    if (start_clr) start_seen <= 1'b0;
    else start_seen <= i_scl_clk;
  end
  always_ff @(posedge i_scl_clk or posedge i_reset) begin
    if (i_reset) start_ack <= 1'b0;
    else start_ack <= start_seen;
  end
  always_ff @(posedge i_scl_clk or posedge i_reset) begin
    if (i_reset) begin
      bit_cnt <= '0;
      shreg <= 8'h00;
      phase <= LK_IDLE;
      ack_pend <= 1'b0;
      o_ptr <= 8'h00;
      o_ptr_tgl <= 1'b0;
      o_wr_tgl <= 1'b0;
      o_wr_addr <= 8'h00;
      o_wr_data <= 8'h00;
    end else if (start_seen) begin
      bit_cnt <= 4'h1;
      shreg <= {7'h00, i_sda_in};
      phase <= LK_ADDR;
      ack_pend <= 1'b0;
    end else if (bit_cnt == 4'h8) begin
      bit_cnt <= 4'h0;
      ack_pend <= 1'b0;
      // A master acknowledge after a read byte moves to the next register.
      if (phase == LK_RDATA && !ack_pend) begin
        if (i_sda_in) begin
          phase <= LK_IDLE;
        end else begin
          o_ptr <= o_ptr + 8'h01;
          o_ptr_tgl <= ~o_ptr_tgl;
        end
      end
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      shreg <= byte_now;
      if (bit_cnt == 4'h7) begin
        case (phase)
          LK_ADDR: begin
            if (byte_now[7:1] == DEV_ADDR) begin
              phase <= byte_now[0] ? LK_RDATA : LK_PTR;
              ack_pend <= 1'b1;
            end else begin
              phase <= LK_IDLE;
            end
          end
          LK_PTR: begin
            o_ptr <= byte_now;
            o_ptr_tgl <= ~o_ptr_tgl;
            phase <= LK_WDATA;
            ack_pend <= 1'b1;
          end
          LK_WDATA: begin
            o_wr_addr <= o_ptr;
            o_wr_data <= byte_now;
            o_wr_tgl <= ~o_wr_tgl;
            o_ptr <= o_ptr + 8'h01;
            o_ptr_tgl <= ~o_ptr_tgl;
            ack_pend <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end
  // The core's read word is quasi-static: it settles long before this edge uses it.
  always_ff @(negedge i_scl_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b1;
      tx_byte <= 8'h00;
      o_rc_tgl <= 1'b0;
    end else if (start_seen) begin
      o_sda_oe_n <= 1'b1;
    end else if (bit_cnt == 4'h8) begin
      o_sda_oe_n <= !ack_pend;
    end else if (phase == LK_RDATA) begin
      if (bit_cnt == 4'h0) begin
        tx_byte <= i_rd_data;
        o_sda_oe_n <= i_rd_data[7];
        if (o_ptr == REG_INT_STATUS) o_rc_tgl <= ~o_rc_tgl;
      end else begin
        o_sda_oe_n <= tx_byte[~bit_cnt[2:0]];
      end
    end else begin
      o_sda_oe_n <= 1'b1;
    end
  end
endmodule // tms_i2c_link

// ### tb/tb_i2c_host.sv
`timescale 1ns/1ps
module tb_i2c_host (
  output logic o_scl,
  output logic o_pull_low,
  input wire logic i_sda
);
  // Phases of 24 ns; the core fetches a read word within three of its cycles.
  localparam time HALF = 24;
  initial begin
    o_scl = 1'b1;
    o_pull_low = 1'b0;
  end
  task automatic start_cond();
    o_pull_low = 1'b0;
    #HALF o_scl = 1'b1;
    #HALF o_pull_low = 1'b1;
    #HALF o_scl = 1'b0;
  endtask
  // The clock is left high after a stop, so it stands still between frames.
  task automatic stop_cond();
    o_pull_low = 1'b1;
    #HALF o_scl = 1'b1;
    #HALF o_pull_low = 1'b0;
    #HALF;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_pull_low = !tx[i];
      #HALF o_scl = 1'b1;
      rx[i] = i_sda;
      #HALF o_scl = 1'b0;
    end
    o_pull_low = 1'b0;
    #HALF o_scl = 1'b1;
    ack = !i_sda;
    #HALF o_scl = 1'b0;
  endtask
endmodule // tb_i2c_host

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tms_pkg::*;
  localparam int BASE = 20;
  localparam int INTEG = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cen_low = 1'b0;
  logic start_pin = 1'b0;
  logic scl, host_low, sda_oe_n, sda_out, irq_oe_n, irq_out, bias, pulse_en, thr_en, done, ack;
  logic [3:0] rng;
  logic [7:0] fine, thr, rdv, rx;
  int fail_count = 0, total_checks = 0, done_count = 0, integ_count = 0, cyc = 0, last_done = 0, gap = 0;
  // Both lines have pull-ups; a released driver reads back high.
  wire sda = !(host_low || (!sda_oe_n && !sda_out));
  wire irq_pin = irq_oe_n ? 1'b1 : irq_out;
  initial begin
    forever #2 clk = ~clk;
  end
  tms_ctrl #(.INTEG_CYCLES(INTEG), .BASE_CYCLES(BASE)) u_dut (.i_core_clk(clk), .i_reset(rst), .i_clk_en(1'b1),
    .i_scl_clk(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_chip_enable_low(cen_low),
    .i_sample_start(start_pin), .o_irq_out(irq_out), .o_irq_oe_n(irq_oe_n), .o_bias_enable(bias),
    .o_emitter_pulse_en(pulse_en), .o_emitter_range(rng), .o_emitter_fine(fine), .o_threshold_en(thr_en),
    .o_threshold_code(thr), .o_meas_done(done));
  tb_i2c_host u_host (.o_scl(scl), .o_pull_low(host_low), .i_sda(sda));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pulse_en === 1'b1) integ_count <= integ_count + 1;
    if (done === 1'b1) begin
      done_count <= done_count + 1;
      gap <= cyc - last_done;
      last_done <= cyc;
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.start_cond();
    u_host.xfer({I2C_DEV_ADDR_DEF, 1'b0}, rx, ack);
    chk("ack", 8'h01, {7'h00, ack});
    u_host.xfer(a, rx, ack);
    u_host.xfer(d, rx, ack);
    u_host.stop_cond();
    tick(8);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    u_host.start_cond();
    u_host.xfer({I2C_DEV_ADDR_DEF, 1'b0}, rx, ack);
    u_host.xfer(a, rx, ack);
    u_host.start_cond();
    u_host.xfer({I2C_DEV_ADDR_DEF, 1'b1}, rx, ack);
    u_host.xfer(8'hFF, rdv, ack);
    u_host.stop_cond();
    chk(what, exp, rdv);
  endtask
  task automatic trig();
    start_pin = 1'b1;
    tick(4);
    start_pin = 1'b0;
  endtask
  task automatic wait_done(input int n);
    for (int i = 0; i < 3000 && done_count < n; i++) tick();
    if (done_count < n) begin
      fail_count++;
      complete_run();
    end
  endtask
  initial begin
    int n0;
    tick(10);
    rst = 1'b0;
    tick(4);
    chk("irq_oe_n", 8'h01, {7'h0, irq_oe_n});
    chk("bias", 8'h01, {7'h0, bias});
    rchk("sw_disable", REG_SW_DISABLE, 8'h00);
    rchk("mode", REG_MODE, 8'h00);
    rchk("unmapped", 8'h7E, 8'h00);
    wr(REG_EMIT_RANGE, 8'h0A);
    wr(REG_EMIT_FINE, 8'h5C);
    wr(REG_THRESHOLD, 8'h1E);
    chk("range", 8'h0A, {4'h0, rng});
    chk("fine", 8'h5C, fine);
    chk("threshold", 8'h1E, thr);
    wr(REG_INT_CTRL, 8'h01);
    wr(REG_MODE, 8'h01);
    integ_count = 0;
    trig();
    for (int i = 0; i < 20 && pulse_en !== 1'b1; i++) tick();
    chk("thr_en", 8'h01, {7'h0, thr_en});
    // A second trigger lands while the first measurement still integrates.
    // The idle cycle lets the pin fall first, so the second pulse is a fresh edge.
    tick();
    trig();
    wait_done(1);
    tick(2);
    chk("irq_pin", 8'h00, {7'h0, irq_pin});
    tick(60);
    chk("integ", 8'(INTEG), 8'(integ_count));
    chk("done", 8'h01, 8'(done_count));
    chk("thr_idle", 8'h00, {7'h0, thr_en});
    chk("irq_held", 8'h00, {7'h0, irq_oe_n});
    rchk("status", REG_INT_STATUS, 8'h01);
    tick(4);
    chk("irq_free", 8'h01, {7'h0, irq_oe_n});
    rchk("status_clr", REG_INT_STATUS, 8'h00);
    wr(REG_COMMAND, CMD_SOFT_START);
    wait_done(2);
    chk("soft_start", 8'h02, 8'(done_count));
    wr(REG_SAMPLE_PERIOD, 8'h02);
    wr(REG_PERIOD_RANGE, 8'h01);
    wr(REG_MODE, 8'h00);
    trig();
    wait_done(done_count + 3);
    chk("period", 8'(BASE * 5), 8'(gap));
    chk("irq_cont", 8'h00, {7'h0, irq_oe_n});
    wr(REG_COMMAND, CMD_SOFT_CLEAR);
    tick(20);
    n0 = done_count;
    tick(300);
    chk("halted", 8'(n0), 8'(done_count));
    rchk("meas_count", REG_MEAS_COUNT, 8'h00);
    wr(REG_SW_DISABLE, 8'h01);
    chk("bias_sw", 8'h00, {7'h0, bias});
    trig();
    tick(40);
    chk("no_meas", 8'(n0), 8'(done_count));
    rchk("fine_kept", REG_EMIT_FINE, 8'h5C);
    wr(REG_SW_DISABLE, 8'h00);
    chk("bias_on", 8'h01, {7'h0, bias});
    cen_low = 1'b1;
    tick(6);
    chk("bias_pin", 8'h00, {7'h0, bias});
    cen_low = 1'b0;
    tick(6);
    rchk("thr_kept", REG_THRESHOLD, 8'h1E);
    wr(REG_POWER_STATUS, 8'h00);
    wr(REG_COMMAND, CMD_SOFT_RESET);
    chk("fine_rst", 8'h00, fine);
    rchk("irq_en_rst", REG_INT_CTRL, 8'h00);
    rchk("brownout", REG_POWER_STATUS, 8'h00);
    complete_run();
  end
endmodule // testbench
